// ---- rtl/clock_select_output_cfg_regs.sv ----
`timescale 1ns/10ps
module clock_select_output_cfg_regs (
	// Clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        reset_i,
	// Control port access
	input  wire clk_cfg_pkg::reg_req_type    req_i,
	output logic [7:0]                       rdata_o,
	output logic                             rvalid_o,
	// Selection and clock inputs
	input  wire clk_cfg_pkg::select_ctl_type sel_i,
	input  wire logic                        bypass_i,
	input  wire logic                        clock_out_one_i,
	input  wire logic                        clock_out_two_i,
	// Derived controls
	output clk_cfg_pkg::active_input_type    active_input_o,
	output logic                             in_forced_hold_o,
	output logic [4:0]                       history_delay_o,
	output logic [1:0]                       cmos_drive_level_o,
	output logic                             sleep_o,
	output logic [2:0]                       out_one_format_o,
	output logic [2:0]                       out_two_format_o,
	output logic                             out_one_enable_o,
	output logic                             out_two_enable_o,
	output logic [2:0]                       offset_alarm_ref_select_o,
	output logic                             clock_output_one_o,
	output logic                             clock_output_two_o,
	output logic                             cmos_bypass_conflict_o
);

	// ************************************************************
	// Address decode
	// ************************************************************
	logic        in_range;
	logic [2:0]  idx;
	logic [39:0] regs;
	logic [7:0]  mem_rdata;
	logic        rd_pend_r;
	logic        rd_hit_r;

	assign in_range = req_i.addr >= clk_cfg_pkg::select_history_offset &&
	                  req_i.addr <= clk_cfg_pkg::static_hold_offset;
	assign idx      = in_range ? 3'(req_i.addr - clk_cfg_pkg::first_offset) : 3'h7;

	cfg_reg_mem u_mem (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.wr_i      (req_i.wr && in_range),
		.idx_i     (idx),
		.wdata_i   (req_i.wdata),
		.rd_idx_i  (idx),
		.rdata_o   (mem_rdata),
		.all_o     (regs)
	);

	// ************************************************************
	// Field extraction
	// ************************************************************
	logic [7:0] r4;
	logic [7:0] r5;
	logic [7:0] r6;
	logic [7:0] r7;
	logic [7:0] r8;
	assign r4 = regs[7:0];
	assign r5 = regs[15:8];
	assign r6 = regs[23:16];
	assign r7 = regs[31:24];
	assign r8 = regs[39:32];

	logic [1:0] select_method;
	logic       sleep;
	logic [2:0] out_two_fmt;
	logic [2:0] out_one_fmt;
	logic [1:0] out_two_static_hold;
	logic [1:0] out_one_static_hold;

	assign select_method       = r4[clk_cfg_pkg::select_method_lsb +: 2];
	assign sleep               = r6[clk_cfg_pkg::sleep_bit];
	assign out_two_fmt         = r6[clk_cfg_pkg::out_two_format_lsb +: 3];
	assign out_one_fmt         = r6[clk_cfg_pkg::out_one_format_lsb +: 3];
	assign out_two_static_hold = r8[clk_cfg_pkg::out_two_hold_lsb +: 2];
	assign out_one_static_hold = r8[clk_cfg_pkg::out_one_hold_lsb +: 2];

	// Format code drives a buffer only for a valid, non-disable code
	function automatic logic fmt_active(input logic [2:0] f);
		fmt_active = (f == clk_cfg_pkg::fmt_cmos)   || (f == clk_cfg_pkg::fmt_lvds_low) ||
		             (f == clk_cfg_pkg::fmt_lvpecl) || (f == clk_cfg_pkg::fmt_cml) ||
		             (f == clk_cfg_pkg::fmt_lvds);
	endfunction : fmt_active

	// Maps a two-bit input code to an input
	function automatic clk_cfg_pkg::active_input_type code_input(input logic [1:0] c);
		if (c == clk_cfg_pkg::prio_input_one) begin
			code_input = clk_cfg_pkg::input_one;
		end else if (c == clk_cfg_pkg::prio_input_two) begin
			code_input = clk_cfg_pkg::input_two;
		end else begin
			code_input = clk_cfg_pkg::input_none;
		end
	endfunction : code_input

	function automatic logic input_ok(input clk_cfg_pkg::active_input_type a,
	                                  input clk_cfg_pkg::select_ctl_type s);
		input_ok = (a == clk_cfg_pkg::input_one && s.input_one_valid) ||
		           (a == clk_cfg_pkg::input_two && s.input_two_valid);
	endfunction : input_ok

	// ************************************************************
	// Input selection
	// ************************************************************
	clk_cfg_pkg::active_input_type manual_choice;
	clk_cfg_pkg::active_input_type first_prio;
	clk_cfg_pkg::active_input_type second_prio;
	clk_cfg_pkg::active_input_type active_r;
	clk_cfg_pkg::active_input_type active_nxt;

	// pin control wins over register field
	assign manual_choice = sel_i.pin_select_control ?
	                       (sel_i.select_pin ? clk_cfg_pkg::input_two : clk_cfg_pkg::input_one) :
	                       code_input(sel_i.register_input_choice);
	assign first_prio    = code_input(sel_i.first_priority_input);
	assign second_prio   = code_input(sel_i.second_priority_input);

	// Selection decision; revertive returns to first priority once valid,
	// non-revertive only moves away when the current input fails
	always_comb begin
		active_nxt = active_r;
		if (sel_i.forced_hold) begin
			active_nxt = clk_cfg_pkg::input_none;
		end else if (select_method == clk_cfg_pkg::method_manual) begin
			active_nxt = manual_choice;
		end else if (select_method == clk_cfg_pkg::method_auto_rev) begin
			if (input_ok(first_prio, sel_i)) begin
				active_nxt = first_prio;
			end else if (input_ok(second_prio, sel_i)) begin
				active_nxt = second_prio;
			end
		end else if (select_method == clk_cfg_pkg::method_auto_nonrev) begin
			if (!input_ok(active_r, sel_i)) begin
				if (input_ok(first_prio, sel_i)) begin
					active_nxt = first_prio;
				end else if (input_ok(second_prio, sel_i)) begin
					active_nxt = second_prio;
				end
			end
		end
		// Reserved method code keeps the current choice
	end

	// ************************************************************
	// Output enables
	// ************************************************************
	logic one_en;
	logic two_en;
	assign one_en = !sleep && fmt_active(out_one_fmt);
	assign two_en = !sleep && fmt_active(out_two_fmt);

	// ************************************************************
	// Glitch-free static holds
	// ************************************************************
	logic one_level;
	logic two_level;

	static_hold_gate u_hold_one (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.hold_code_i (out_one_static_hold),
		.clk_level_i (clock_out_one_i),
		.level_o     (one_level),
		.held_o      ()
	);

	static_hold_gate u_hold_two (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.hold_code_i (out_two_static_hold),
		.clk_level_i (clock_out_two_i),
		.level_o     (two_level),
		.held_o      ()
	);

	// ************************************************************
	// Registered outputs
	// ************************************************************
	// Every output leaves a flip-flop, one cycle behind its register; the clock outputs trail the static hold field by two
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			active_r                  <= clk_cfg_pkg::input_none;
			in_forced_hold_o          <= 1'b0;
			history_delay_o           <= 5'h00;
			cmos_drive_level_o        <= 2'h0;
			sleep_o                   <= 1'b0;
			out_one_format_o          <= 3'h0;
			out_two_format_o          <= 3'h0;
			out_one_enable_o          <= 1'b0;
			out_two_enable_o          <= 1'b0;
			offset_alarm_ref_select_o <= 3'h0;
			clock_output_one_o        <= 1'b0;
			clock_output_two_o        <= 1'b0;
			cmos_bypass_conflict_o    <= 1'b0;
		end else begin
			active_r                  <= active_nxt;
			in_forced_hold_o          <= sel_i.forced_hold;
			history_delay_o           <= r4[4:0];
			cmos_drive_level_o        <= r5[7:6];
			sleep_o                   <= sleep;
			out_one_format_o          <= out_one_fmt;
			out_two_format_o          <= out_two_fmt;
			out_one_enable_o          <= one_en;
			out_two_enable_o          <= two_en;
			offset_alarm_ref_select_o <= r7[2:0];
			clock_output_one_o        <= one_en & one_level;
			clock_output_two_o        <= two_en & two_level;
			// flag only; software must avoid this
			cmos_bypass_conflict_o    <= bypass_i &&
			                             (out_one_fmt == clk_cfg_pkg::fmt_cmos ||
			                              out_two_fmt == clk_cfg_pkg::fmt_cmos);
		end
	end

	assign active_input_o = active_r;

	// Read answer two cycles after the request
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_pend_r <= 1'b0;
			rd_hit_r  <= 1'b0;
			rvalid_o  <= 1'b0;
			rdata_o   <= 8'h00;
		end else begin
			rd_pend_r <= req_i.rd;
			rd_hit_r  <= in_range;
			rvalid_o  <= rd_pend_r;
			rdata_o   <= (rd_pend_r && rd_hit_r) ? mem_rdata : 8'h00;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	a_sleep_disables: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		sleep |=> !out_one_enable_o && !out_two_enable_o)
		else $error("outputs enabled during sleep");
	a_sleep_low_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		sleep |=> !clock_output_one_o && !clock_output_two_o)
		else $error("clock output toggles during sleep");
	a_forced_hold_sel: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		sel_i.forced_hold |=> active_input_o == clk_cfg_pkg::input_none)
		else $error("input active in forced hold");
	a_manual_pin_sel: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!sel_i.forced_hold && select_method == clk_cfg_pkg::method_manual &&
		sel_i.pin_select_control && sel_i.select_pin
		|=> active_input_o == clk_cfg_pkg::input_two)
		else $error("pin selection ignored");
	a_reserved_fixed: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		r5[5:0] == clk_cfg_pkg::drive_strength_reset[5:0] && r4[5] == 1'b0 &&
		r6[7] == 1'b0 && r7[7:3] == 5'h00 && r8[3:0] == 4'h0)
		else $error("reserved bit changed");
	a_format_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		out_one_fmt == clk_cfg_pkg::fmt_disable |=> !out_one_enable_o)
		else $error("first output enabled while disabled");
	a_format_two_en: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!sleep && out_two_fmt == clk_cfg_pkg::fmt_lvds |=> out_two_enable_o)
		else $error("second output not enabled");
	a_hold_static: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		u_hold_one.held_r && $stable(u_hold_one.held_r) |-> $stable(one_level))
		else $error("held output level moved");
	a_revert_prio: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!sel_i.forced_hold && select_method == clk_cfg_pkg::method_auto_rev &&
		input_ok(first_prio, sel_i) |=> active_input_o == $past(first_prio))
		else $error("revertive mode missed first priority");
	a_write_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		req_i.wr && req_i.addr == clk_cfg_pkg::alarm_ref_offset
		|=> ##1 offset_alarm_ref_select_o == $past(req_i.wdata[2:0], 2))
		else $error("alarm reference not loaded");

	c_sleep_entry: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(sleep_o));
	c_auto_switch: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		active_input_o == clk_cfg_pkg::input_one ##1 active_input_o == clk_cfg_pkg::input_two);
	c_hold_entry: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		$rose(u_hold_two.held_r));
	c_read_back: cover property (@(posedge sys_clk_i) disable iff (reset_i) rvalid_o);

endmodule : clock_select_output_cfg_regs

// ---- rtl/clk_cfg_pkg.sv ----
package clk_cfg_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] select_history_offset = 8'h04;
	localparam logic [7:0] drive_strength_offset = 8'h05;
	localparam logic [7:0] format_sleep_offset   = 8'h06;
	localparam logic [7:0] alarm_ref_offset      = 8'h07;
	localparam logic [7:0] static_hold_offset    = 8'h08;
	localparam logic [7:0] first_offset          = 8'h04;
	localparam int         reg_count             = 5;

	// Reset values
	localparam logic [7:0] select_history_reset  = 8'h12;
	localparam logic [7:0] drive_strength_reset  = 8'hED;
	localparam logic [7:0] format_sleep_reset    = 8'h00;
	localparam logic [7:0] alarm_ref_reset       = 8'h00;
	localparam logic [7:0] static_hold_reset     = 8'h00;

	// Writable bit masks; cleared bits are reserved and fixed
	localparam logic [7:0] select_history_mask   = 8'hDF;
	localparam logic [7:0] drive_strength_mask   = 8'hC0;
	localparam logic [7:0] format_sleep_mask     = 8'h7F;
	localparam logic [7:0] alarm_ref_mask        = 8'h07;
	localparam logic [7:0] static_hold_mask      = 8'hF0;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int select_method_lsb   = 6;
	localparam int sleep_bit           = 6;
	localparam int out_two_format_lsb  = 3;
	localparam int out_one_format_lsb  = 0;
	localparam int out_two_hold_lsb    = 6;
	localparam int out_one_hold_lsb    = 4;

	// ************************************************************
	// Encodings
	// ************************************************************
	localparam logic [1:0] method_manual      = 2'h0;
	localparam logic [1:0] method_auto_nonrev = 2'h1;
	localparam logic [1:0] method_auto_rev    = 2'h2;
	localparam logic [1:0] prio_input_one     = 2'h0;
	localparam logic [1:0] prio_input_two     = 2'h1;
	localparam logic [2:0] fmt_disable        = 3'h1;
	localparam logic [2:0] fmt_cmos           = 3'h2;
	localparam logic [2:0] fmt_lvds_low       = 3'h3;
	localparam logic [2:0] fmt_lvpecl         = 3'h5;
	localparam logic [2:0] fmt_cml            = 3'h6;
	localparam logic [2:0] fmt_lvds           = 3'h7;
	localparam logic [2:0] ref_crystal        = 3'h0;
	localparam logic [2:0] ref_input_one      = 3'h1;
	localparam logic [2:0] ref_input_two      = 3'h2;
	localparam logic [1:0] hold_none          = 2'h0;
	localparam logic [1:0] hold_low           = 2'h1;
	localparam logic [1:0] hold_high          = 2'h2;

	// Input chosen as active
	typedef enum logic [1:0] {
		input_none,
		input_one,
		input_two
	} active_input_type;

	// Host register access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	// Selection inputs from the rest of the device
	typedef struct packed {
		logic       forced_hold;
		logic       pin_select_control;
		logic [1:0] register_input_choice;
		logic       select_pin;
		logic [1:0] first_priority_input;
		logic [1:0] second_priority_input;
		logic       input_one_valid;
		logic       input_two_valid;
	} select_ctl_type;

endpackage : clk_cfg_pkg

// ---- rtl/cfg_reg_mem.sv ----
`timescale 1ns/10ps
// Small register store; read data leaves a register
module cfg_reg_mem (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	// Access
	input  wire logic       wr_i,
	input  wire logic [2:0] idx_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [2:0] rd_idx_i,
	// Data
	output logic [7:0]      rdata_o,
	output logic [39:0]     all_o
);

	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] mem_r [clk_cfg_pkg::reg_count];

	// Reset values and writable masks per slot
	function automatic logic [7:0] reset_of(input int i);
		case (i)
			0: reset_of = clk_cfg_pkg::select_history_reset;
			1: reset_of = clk_cfg_pkg::drive_strength_reset;
			2: reset_of = clk_cfg_pkg::format_sleep_reset;
			3: reset_of = clk_cfg_pkg::alarm_ref_reset;
			default: reset_of = clk_cfg_pkg::static_hold_reset;
		endcase
	endfunction : reset_of

	function automatic logic [7:0] mask_of(input int i);
		case (i)
			0: mask_of = clk_cfg_pkg::select_history_mask;
			1: mask_of = clk_cfg_pkg::drive_strength_mask;
			2: mask_of = clk_cfg_pkg::format_sleep_mask;
			3: mask_of = clk_cfg_pkg::alarm_ref_mask;
			default: mask_of = clk_cfg_pkg::static_hold_mask;
		endcase
	endfunction : mask_of

	genvar g;
	generate
		for (g = 0; g < clk_cfg_pkg::reg_count; g++) begin : g_slot
			// Reserved bits keep their reset value on write
			always_ff @(posedge sys_clk_i or posedge reset_i) begin
				if (reset_i) begin
					mem_r[g] <= reset_of(g);
				end else if (wr_i && idx_i == 3'(g)) begin
					mem_r[g] <= (wdata_i & mask_of(g)) | (reset_of(g) & ~mask_of(g));
				end
			end
			assign all_o[g*8 +: 8] = mem_r[g];
		end
	endgenerate

	// Registered read port
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (rd_idx_i < 3'(clk_cfg_pkg::reg_count)) begin
			rdata_o <= mem_r[rd_idx_i];
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule : cfg_reg_mem

// ---- rtl/static_hold_gate.sv ----
`timescale 1ns/10ps
// Glitch-free static hold for one output clock
module static_hold_gate (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	// Control
	input  wire logic [1:0] hold_code_i,
	input  wire logic       clk_level_i,
	// Output
	output logic            level_o,
	output logic            held_o
);

	// ************************************************************
	// Hold tracker
	// ************************************************************
	// Hold is only entered or left when the running clock already sits at
	// the held level, so no shortened pulse is produced at either edge.
	logic       want_hold;
	logic       want_level;
	logic       held_r;
	logic       hold_level_r;
	logic       held_nxt;
	logic       hold_level_nxt;

	assign want_hold  = (hold_code_i == clk_cfg_pkg::hold_low) ||
	                    (hold_code_i == clk_cfg_pkg::hold_high);
	assign want_level = (hold_code_i == clk_cfg_pkg::hold_high);

	always_comb begin
		held_nxt       = held_r;
		hold_level_nxt = hold_level_r;
		if (!held_r && want_hold && clk_level_i == want_level) begin
			held_nxt       = 1'b1;
			hold_level_nxt = want_level;
		end else if (held_r && (!want_hold || want_level != hold_level_r)
		             && clk_level_i == hold_level_r) begin
			held_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			held_r       <= 1'b0;
			hold_level_r <= 1'b0;
			level_o      <= 1'b0;
		end else begin
			held_r       <= held_nxt;
			hold_level_r <= hold_level_nxt;
			level_o      <= held_nxt ? hold_level_nxt : clk_level_i;
		end
	end

	assign held_o = held_r;

endmodule : static_hold_gate

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
	// Clock, reset and stimulus
	logic                         sys_clk_i = 1'b0;
	logic                         reset_i   = 1'b1;
	clk_cfg_pkg::reg_req_type     req       = '0;
	clk_cfg_pkg::select_ctl_type  sel       = '0;
	logic                         bypass    = 1'b0;
	logic                         ck1       = 1'b0;
	logic                         ck2       = 1'b1;
	// Observed outputs
	logic [7:0]                   rdata;
	logic                         rvalid;
	clk_cfg_pkg::active_input_type act;
	logic                         fhold, slp, en1, en2, co1, co2, conf;
	logic [4:0]                   hdel;
	logic [1:0]                   drv;
	logic [2:0]                   f1, f2, aref;
	// Bench state
	int                           fail_count = 0;
	int                           n_tests    = 0;
	int                           seed       = 46008;
	logic [7:0]                   m [5];
	logic [7:0]                   a, d;
	localparam logic [7:0] rst_v [5] = '{8'h12, 8'hED, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] msk_v [5] = '{8'hDF, 8'hC0, 8'h7F, 8'h07, 8'hF0};

	// Design under test; all inputs driven by the bench
	clock_select_output_cfg_regs i_clock_select_output_cfg_regs (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata),
		.rvalid_o(rvalid), .sel_i(sel), .bypass_i(bypass), .clock_out_one_i(ck1),
		.clock_out_two_i(ck2), .active_input_o(act), .in_forced_hold_o(fhold),
		.history_delay_o(hdel), .cmos_drive_level_o(drv), .sleep_o(slp),
		.out_one_format_o(f1), .out_two_format_o(f2), .out_one_enable_o(en1),
		.out_two_enable_o(en2), .offset_alarm_ref_select_o(aref),
		.clock_output_one_o(co1), .clock_output_two_o(co2), .cmos_bypass_conflict_o(conf));

	// 100 MHz clock
	always #5 sys_clk_i = ~sys_clk_i;
	// Divided clocks keep toggling so hold entry has edges to wait for
	always @(negedge sys_clk_i) begin
		ck1 <= ~ck1;
		ck2 <= ~ck2;
	end

	// ************************************************************
	// Checking and bus tasks
	// ************************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Output enabled only for the five live format codes and out of sleep
	function automatic logic en_exp(input logic [2:0] f, input logic s);
		return !s && (f == 3'h2 || f == 3'h3 || f >= 3'h5);
	endfunction : en_exp

	// One-cycle write pulse, derived outputs settle two edges later
	task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
		req = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
		@(negedge sys_clk_i) req.wr = 1'b0;
		if (ad >= 8'h04 && ad <= 8'h08) m[ad-4] = (m[ad-4] & ~msk_v[ad-4]) | (wd & msk_v[ad-4]);
		@(negedge sys_clk_i);
	endtask : wr

	// Read answer stands for the cycle after the edge that follows the request edge
	task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
		req = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
		@(negedge sys_clk_i) req.rd = 1'b0;
		@(negedge sys_clk_i);
		chk(rvalid, 1'b1);
		chk(rdata, exp);
		@(negedge sys_clk_i) chk(rvalid, 1'b0);
	endtask : rd_chk

	// Field copies and enables against the bench's register image
	task automatic fields();
		chk(hdel, m[0][4:0]);
		chk(drv, m[1][7:6]);
		chk(slp, m[2][6]);
		chk(f2, m[2][5:3]);
		chk(f1, m[2][2:0]);
		chk(en1, en_exp(m[2][2:0], m[2][6]));
		chk(en2, en_exp(m[2][5:3], m[2][6]));
		chk(aref, m[3][2:0]);
	endtask : fields

	task automatic sel_chk(input logic [7:0] exp);
		repeat (2) @(negedge sys_clk_i);
		chk(act, exp);
	endtask : sel_chk

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		m = rst_v;
		repeat (12) @(negedge sys_clk_i);
		reset_i = 1'b0;
		// Reset values and fixed reserved bits
		for (int i = 0; i < 5; i++) rd_chk(8'h04 + i, rst_v[i]);
		fields();
		$display("test reset values done");
		// Random writes including unmapped places, reserved bits stay fixed
		for (int i = 0; i < 30; i++) begin
			a = 8'h03 + ($unsigned($random(seed)) % 7);
			d = $random(seed);
			wr(a, d);
			fields();
			rd_chk(a, (a >= 8'h04 && a <= 8'h08) ? m[a-4] : 8'h00);
		end
		wr(8'h04, 8'hFF);
		rd_chk(8'h04, 8'hDF);
		$display("test random access done");
		// Sleep overrides live formats, then each format code in turn
		wr(8'h06, 8'h7F);
		fields();
		for (int i = 0; i < 8; i++) begin
			wr(8'h06, {2'b00, 3'(7 - i), 3'(i)});
			fields();
		end
		$display("test formats and sleep done");
		// Manual selection by pin, then by register field, then forced hold
		wr(8'h04, 8'h00);
		sel = '{pin_select_control: 1'b1, select_pin: 1'b1, default: '0};
		sel_chk(8'h02);
		sel.pin_select_control = 1'b0;
		sel_chk(8'h01);
		sel.register_input_choice = 2'h1;
		sel_chk(8'h02);
		sel.forced_hold = 1'b1;
		sel_chk(8'h00);
		chk(fhold, 1'b1);
		// Revertive ranking by priority and input validity; forced hold drops here
		sel = '{first_priority_input: 2'h1, second_priority_input: 2'h0,
			input_one_valid: 1'b1, input_two_valid: 1'b1, default: '0};
		wr(8'h04, 8'h80);
		sel_chk(8'h02);
		sel.input_two_valid = 1'b0;
		sel_chk(8'h01);
		sel.input_two_valid = 1'b1;
		sel_chk(8'h02);
		// Non-revertive keeps the current input while it stays valid
		wr(8'h04, 8'h40);
		sel.input_two_valid = 1'b0;
		sel_chk(8'h01);
		sel.input_two_valid = 1'b1;
		sel_chk(8'h01);
		$display("test selection done");
		// CMOS while bypassed is flagged
		bypass = 1'b1;
		wr(8'h06, 8'h3A);
		chk(conf, 1'b1);
		bypass = 1'b0;
		// Static hold: out one low, out two high, then release
		wr(8'h06, 8'h3F);
		wr(8'h08, 8'h90);
		repeat (6) @(negedge sys_clk_i);
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk_i);
			chk(co1, 1'b0);
			chk(co2, 1'b1);
		end
		wr(8'h08, 8'h00);
		repeat (6) @(negedge sys_clk_i);
		d[0] = co1;
		@(negedge sys_clk_i);
		chk(co1, {7'h00, ~d[0]});
		$display("test static hold done");
		conclude();
	end

	// Watchdog well past the expected run length
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule : tb
